// ===== rtl/dbt_bridge.sv
// Purpose: Non-transparent bridge translation, doorbells and mailboxes
// Assumes: All inputs come from logic on clk_in
// Notes: Settings reach the block through a plain write port
//
// Summary of operation
// (RULE1) Eight bridge functions, each serving its own separate host domain.
// (RULE2) Six windows per function, usable as six narrow or three paired wide windows.
// (RULE3) Every window not in table mode translates directly with programmed base and limit, narrow or wide.
// (RULE4) Only the third and fifth windows may use table-driven translation.
// (RULE5) Table mode splits the aperture into at most 24 segments, each own entry.
// (RULE6) One shared table of 64 requester identities serves all functions.
// (RULE7) Crossing requests get translated address and translated requester identity.
// (RULE8) A 32-bit doorbell per direction; ringing sets the same bit on the far side.
// (RULE9) Four message words per direction; a write appears on the far side.
// (RULE10) No limit on outstanding requests; a new request is accepted every cycle.
// (RULE11) Inbound doorbell bits stay set until written one; any set bit raises an event.
`timescale 1ns/1ps
`include "dbt_defines.svh"

module dbt_bridge
	import dbt_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	// Settings write port
	input wire logic cfg_we_in,
	input wire logic [2:0] cfg_func_in,
	input wire dbt_cfg_sel_t cfg_sel_in,
	input wire logic [5:0] cfg_idx_in,
	input wire logic [63:0] cfg_data_in,
	// Request in
	input wire logic req_valid_in,
	input wire logic [2:0] req_func_in,
	input wire dbt_addr_t req_addr_in,
	input wire dbt_id_t req_id_in,
	output logic req_ready_out,
	// Translated request out
	output logic xl_valid_out,
	output logic xl_miss_out,
	output logic [2:0] xl_func_out,
	output logic [2:0] xl_win_out,
	output dbt_addr_t xl_addr_out,
	output dbt_id_t xl_id_out,
	// Doorbells
	input wire logic db_ring_in,
	input wire logic db_ack_in,
	input wire logic db_side_in,
	input wire logic [2:0] db_func_in,
	input wire logic [31:0] db_ring_data_in,
	input wire logic [31:0] db_ack_data_in,
	output logic [15:0] db_event_out,
	// Messages
	input wire logic msg_we_in,
	input wire logic msg_side_in,
	input wire logic [2:0] msg_func_in,
	input wire logic [1:0] msg_idx_in,
	input wire logic [31:0] msg_data_in,
	// Readback
	input wire logic rd_en_in,
	input wire logic rd_side_in,
	input wire logic [2:0] rd_func_in,
	input wire logic [1:0] rd_idx_in,
	output logic [31:0] rd_msg_out,
	output logic [31:0] rd_db_out
);
	// ==================================================================
	// Storage
	dbt_addr_t win_base [`DBT_NFUNC*`DBT_NWIN];
	dbt_addr_t win_limit [`DBT_NFUNC*`DBT_NWIN];
	dbt_addr_t win_xbase [`DBT_NFUNC*`DBT_NWIN];
	logic [31:0] ctl_reg [`DBT_NFUNC];
	logic [63:0] lut_mem [`DBT_NFUNC*2*`DBT_NSEG];
	logic [63:0] map_mem [`DBT_NMAP];
	logic [`DBT_DB_W-1:0] db_reg [2*`DBT_NFUNC];
	logic [`DBT_MSG_W-1:0] msg_mem [2*`DBT_NFUNC*`DBT_NMSG];

	// ==================================================================
	// Functions
	function automatic logic [2:0] first_hit(input logic [5:0] hits);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 5; i >= 0; i--)
		begin
			if (hits[i])
			begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : first_hit

	function automatic logic [5:0] win_slot(input logic [2:0] f, input logic [2:0] w);
		return 6'(f * `DBT_NWIN + w);
	endfunction : win_slot

	// ==================================================================
	// Settings writes
	always_ff @(posedge clk_in)
	begin
		if (ce_in && cfg_we_in && (cfg_idx_in[2:0] < 3'(`DBT_NWIN)))
		begin
			case (cfg_sel_in)
				DBT_CFG_BASE: win_base[win_slot(cfg_func_in, cfg_idx_in[2:0])] <= cfg_data_in;
				DBT_CFG_LIMIT: win_limit[win_slot(cfg_func_in, cfg_idx_in[2:0])] <= cfg_data_in;
				DBT_CFG_XLAT: win_xbase[win_slot(cfg_func_in, cfg_idx_in[2:0])] <= cfg_data_in;
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			for (int i = 0; i < `DBT_NFUNC; i++)
			begin
				ctl_reg[i] <= `DBT_CTL_RESET;
			end
		end
		else if (ce_in && cfg_we_in && cfg_sel_in == DBT_CFG_CTL)
		begin
			ctl_reg[cfg_func_in] <= cfg_data_in[31:0]; // RULE1
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			for (int i = 0; i < `DBT_NFUNC*2*`DBT_NSEG; i++)
			begin
				lut_mem[i] <= 64'h0;
			end
		end
		else if (ce_in && cfg_we_in && cfg_sel_in == DBT_CFG_LUT &&
			cfg_idx_in[4:0] < 5'(`DBT_NSEG))
		begin
			lut_mem[{cfg_func_in, cfg_idx_in[5]} * `DBT_NSEG + cfg_idx_in[4:0]] <= cfg_data_in; // RULE5
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			for (int i = 0; i < `DBT_NMAP; i++)
			begin
				map_mem[i] <= 64'h0;
			end
		end
		else if (ce_in && cfg_we_in && cfg_sel_in == DBT_CFG_MAP)
		begin
			map_mem[cfg_idx_in] <= cfg_data_in; // RULE6
		end
	end

	// ==================================================================
	// Window calculators
	dbt_win_if w_if [`DBT_NWIN] ();
	logic [5:0] hits;
	logic [31:0] ctl_cur;
	logic [127:0] win_res [`DBT_NWIN];
	assign ctl_cur = ctl_reg[req_func_in];
	generate
		for (genvar g = 0; g < `DBT_NWIN; g++)
		begin : g_win
			assign w_if[g].addr = req_addr_in;
			assign w_if[g].base = win_base[win_slot(req_func_in, 3'(g))];
			assign w_if[g].limit = win_limit[win_slot(req_func_in, 3'(g))];
			assign w_if[g].xbase = win_xbase[win_slot(req_func_in, 3'(g))];
			assign w_if[g].wide = ctl_cur[`DBT_CTL_PAIR_LSB + g/2]; // RULE2
			assign w_if[g].en = ctl_cur[`DBT_CTL_EN_LSB + g] &&
				!((g % 2 == 1) && ctl_cur[`DBT_CTL_PAIR_LSB + g/2]); // RULE2
			assign hits[g] = w_if[g].hit;
			assign win_res[g] = {w_if[g].xaddr, w_if[g].off};
			dbt_window u_win
			(
				.win(w_if[g])
			);
		end
	endgenerate

	// ==================================================================
	// Translation decode
	logic [2:0] sel;
	logic lut_mode;
	logic [4:0] shift;
	logic [63:0] seg_idx;
	logic [63:0] lut_word;
	dbt_addr_t off_sel;
	dbt_addr_t dir_addr;
	dbt_addr_t lut_addr;
	dbt_addr_t seg_mask;
	logic id_hit;
	dbt_id_t id_xl;

	always_comb
	begin
		sel = first_hit(hits);
		off_sel = 64'h0;
		dir_addr = 64'h0;
		for (int i = 0; i < `DBT_NWIN; i++)
		begin
			if (hits[i] && 3'(i) == sel)
			begin
				{dir_addr, off_sel} = win_res[i];
			end
		end
	end

	always_comb
	begin
		lut_mode = 1'b0;
		shift = ctl_cur[`DBT_CTL_SH2_LSB +: 5];
		if (sel == `DBT_LUT_WIN_A)
		begin
			lut_mode = ctl_cur[`DBT_CTL_LUT2_BIT]; // RULE4
		end
		else if (sel == `DBT_LUT_WIN_B)
		begin
			lut_mode = ctl_cur[`DBT_CTL_LUT4_BIT]; // RULE4
			shift = ctl_cur[`DBT_CTL_SH4_LSB +: 5];
		end
		seg_idx = off_sel >> shift; // RULE5
		seg_mask = ~(64'hFFFF_FFFF_FFFF_FFFF << shift);
		lut_word = 64'h0;
		if (seg_idx < 64'(`DBT_NSEG))
		begin
			lut_word = lut_mem[{req_func_in, sel == `DBT_LUT_WIN_B} * `DBT_NSEG + 6'(seg_idx)];
		end
		lut_addr = {lut_word[63:1], 1'b0} + (off_sel & seg_mask); // RULE5
	end

	always_comb
	begin
		id_hit = 1'b0;
		id_xl = 16'h0;
		for (int i = 0; i < `DBT_NMAP; i++)
		begin
			if (map_mem[i][`DBT_MAP_VLD_BIT] &&
				map_mem[i][`DBT_MAP_FUNC_LSB +: 3] == req_func_in &&
				map_mem[i][`DBT_MAP_SRC_LSB +: 16] == req_id_in) // RULE6
			begin
				id_hit = 1'b1;
				id_xl = map_mem[i][`DBT_MAP_DST_LSB +: 16]; // RULE7
			end
		end
	end

	// ==================================================================
	// Request pipeline, one request per cycle, no outstanding count
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			req_ready_out <= 1'b0;
			xl_valid_out <= 1'b0;
			xl_miss_out <= 1'b0;
			xl_func_out <= 3'h0;
			xl_win_out <= 3'h0;
			xl_addr_out <= 64'h0;
			xl_id_out <= 16'h0;
		end
		else if (ce_in)
		begin
			req_ready_out <= 1'b1; // RULE10
			xl_valid_out <= req_valid_in && req_ready_out; // RULE10
			if (req_valid_in && req_ready_out)
			begin
				xl_func_out <= req_func_in;
				xl_win_out <= sel;
				xl_id_out <= id_xl; // RULE7
				xl_miss_out <= !(|hits) || !id_hit ||
					(lut_mode && (seg_idx >= 64'(`DBT_NSEG) || !lut_word[`DBT_LUT_VLD_BIT]));
				xl_addr_out <= lut_mode ? lut_addr : dir_addr; // RULE7
			end
		end
	end

	// ==================================================================
	// Doorbells
	generate
		for (genvar d = 0; d < 2*`DBT_NFUNC; d++)
		begin : g_db
			logic [31:0] set_bits;
			logic [31:0] clr_bits;
			assign set_bits = (db_ring_in && {!db_side_in, db_func_in} == 4'(d)) ?
				db_ring_data_in : 32'h0; // RULE8
			assign clr_bits = (db_ack_in && {db_side_in, db_func_in} == 4'(d)) ?
				db_ack_data_in : 32'h0; // RULE11
			always_ff @(posedge clk_in)
			begin
				if (!rst_b_in)
				begin
					db_reg[d] <= 32'h0;
					db_event_out[d] <= 1'b0;
				end
				else if (ce_in)
				begin
					db_reg[d] <= (db_reg[d] & ~clr_bits) | set_bits; // RULE11
					db_event_out[d] <= |((db_reg[d] & ~clr_bits) | set_bits); // RULE11
				end
			end
		end
	endgenerate

	// ==================================================================
	// Messages
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			for (int i = 0; i < 2*`DBT_NFUNC*`DBT_NMSG; i++)
			begin
				msg_mem[i] <= 32'h0;
			end
		end
		else if (ce_in && msg_we_in)
		begin
			msg_mem[{!msg_side_in, msg_func_in, msg_idx_in}] <= msg_data_in; // RULE9
		end
	end

	// ==================================================================
	// Readback
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			rd_msg_out <= 32'h0;
			rd_db_out <= 32'h0;
		end
		else if (ce_in && rd_en_in)
		begin
			rd_msg_out <= msg_mem[{rd_side_in, rd_func_in, rd_idx_in}]; // RULE9
			rd_db_out <= db_reg[{rd_side_in, rd_func_in}]; // RULE8
		end
	end
endmodule : dbt_bridge

// ===== rtl/dbt_defines.svh
// Purpose: Constants of the domain bridge translation block
// Assumes: Single clock, synchronous active-low reset
// Notes: Offsets, field positions, reset values and counts
`ifndef DBT_DEFINES_SVH
`define DBT_DEFINES_SVH

// ==================================================================
// Sizes
`define DBT_NFUNC 8
`define DBT_NWIN 6
`define DBT_NSEG 24
`define DBT_NMAP 64
`define DBT_NMSG 4
`define DBT_DB_W 32
`define DBT_MSG_W 32
`define DBT_ADDR_W 64
`define DBT_ID_W 16

// ==================================================================
// Control word fields, one control word per bridge function
`define DBT_CTL_EN_LSB 0
`define DBT_CTL_PAIR_LSB 6
`define DBT_CTL_LUT2_BIT 9
`define DBT_CTL_LUT4_BIT 10
`define DBT_CTL_SH2_LSB 16
`define DBT_CTL_SH4_LSB 24
`define DBT_CTL_RESET 32'h0000_0000

// ==================================================================
// Table windows and map entry fields
`define DBT_LUT_WIN_A 3'h2
`define DBT_LUT_WIN_B 3'h4
`define DBT_LUT_VLD_BIT 0
`define DBT_MAP_SRC_LSB 0
`define DBT_MAP_DST_LSB 16
`define DBT_MAP_VLD_BIT 32
`define DBT_MAP_FUNC_LSB 33

`endif

// ===== rtl/dbt_pkg.sv
// Purpose: Types of the domain bridge translation block
// Assumes: Constants come from dbt_defines.svh
// Notes: Types only
`include "dbt_defines.svh"

package dbt_pkg;
	// ==================================================================
	// Configuration targets
	typedef enum logic [2:0]
	{
		DBT_CFG_BASE = 3'h0,
		DBT_CFG_LIMIT = 3'h1,
		DBT_CFG_XLAT = 3'h2,
		DBT_CFG_CTL = 3'h3,
		DBT_CFG_LUT = 3'h4,
		DBT_CFG_MAP = 3'h5
	} dbt_cfg_sel_t;

	typedef logic [`DBT_ADDR_W-1:0] dbt_addr_t;
	typedef logic [`DBT_ID_W-1:0] dbt_id_t;
endpackage : dbt_pkg

// ===== rtl/dbt_win_if.sv
// Purpose: Carrier between the bridge and one window calculator
// Assumes: Combinational use inside one clock domain
// Notes: One instance per base address window
`timescale 1ns/1ps

interface dbt_win_if;
	import dbt_pkg::*;
	dbt_addr_t addr;
	dbt_addr_t base;
	dbt_addr_t limit;
	dbt_addr_t xbase;
	logic en;
	logic wide;
	logic hit;
	dbt_addr_t off;
	dbt_addr_t xaddr;

	modport calc
	(
		input addr, base, limit, xbase, en, wide,
		output hit, off, xaddr
	);
	modport user
	(
		output addr, base, limit, xbase, en, wide,
		input hit, off, xaddr
	);
endinterface : dbt_win_if

// ===== rtl/dbt_window.sv
// Purpose: Base and limit hit check and direct translation of one window
// Assumes: Window settings held by the caller
// Notes: Narrow form clears the upper address half
`timescale 1ns/1ps

module dbt_window
	import dbt_pkg::*;
(
	// Window carrier
	dbt_win_if.calc win
);
	dbt_addr_t base_eff;
	dbt_addr_t limit_eff;
	dbt_addr_t sum;

	// ==================================================================
	// Hit check
	assign base_eff = win.wide ? win.base : {32'h0000_0000, win.base[31:0]}; // RULE3
	assign limit_eff = win.wide ? win.limit : {32'h0000_0000, win.limit[31:0]}; // RULE3
	assign win.hit = win.en && (win.wide || (win.addr[63:32] == 32'h0000_0000)) &&
		(win.addr >= base_eff) && (win.addr <= limit_eff); // RULE3
	assign win.off = win.addr - base_eff;

	// ==================================================================
	// Direct translation
	assign sum = win.xbase + win.off; // RULE3
	assign win.xaddr = win.wide ? sum : {32'h0000_0000, sum[31:0]}; // RULE2
endmodule : dbt_window

// ===== sim/dbt_bridge_sva.sv
// Purpose: Port checks of the bridge
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every bridge instance
`timescale 1ns/1ps

module dbt_bridge_sva
	import dbt_pkg::*;
(
	// Watched ports
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic req_valid_in,
	input wire logic req_ready_out,
	input wire logic xl_valid_out,
	input wire dbt_addr_t xl_addr_out,
	input wire dbt_id_t xl_id_out,
	input wire logic db_ring_in,
	input wire logic db_ack_in,
	input wire logic db_side_in,
	input wire logic [2:0] db_func_in,
	input wire logic [31:0] db_ring_data_in,
	input wire logic [15:0] db_event_out,
	input wire logic rd_en_in,
	input wire logic [31:0] rd_db_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	// ==================================================================
	// Assertions
	a_reset_clears_out: assert property ($rose(rst_b_in) && $past(ce_in) |->
		!req_ready_out && !xl_valid_out && db_event_out == 16'h0000)
		else $error("outputs not clear after reset");
	a_ready_stays_up: assert property (ce_in |=> req_ready_out)
		else $error("request ready dropped");
	a_req_gives_pulse: assert property (ce_in && req_valid_in && req_ready_out |=> xl_valid_out)
		else $error("accepted request gave no result");
	a_pulse_has_cause: assert property (xl_valid_out && $past(ce_in) |->
		$past(req_valid_in && req_ready_out))
		else $error("result without request");
	a_xl_fields_hold: assert property (!(ce_in && req_valid_in) |=>
		$stable(xl_addr_out) && $stable(xl_id_out))
		else $error("result fields changed without request");
	a_ring_sets_far: assert property (ce_in && db_ring_in && db_ring_data_in != 32'h0 |=>
		db_event_out[{~$past(db_side_in), $past(db_func_in)}])
		else $error("ring did not reach far side");
	a_event_holds_set: assert property (!db_ack_in |=>
		(db_event_out & $past(db_event_out)) == $past(db_event_out))
		else $error("doorbell event dropped without clear");
	a_event_idle_zero: assert property (!db_ring_in && db_event_out == 16'h0000 |=>
		db_event_out == 16'h0000)
		else $error("doorbell event without ring");
	a_rd_db_holds: assert property (!(ce_in && rd_en_in) |=> $stable(rd_db_out))
		else $error("readback changed without read");

	// ==================================================================
	// Covers
	c_req: cover property (req_valid_in ##1 req_valid_in ##1 req_valid_in);
	c_ring: cover property (db_ring_in ##1 db_event_out != 16'h0000);
	c_ack: cover property (db_ack_in);
endmodule : dbt_bridge_sva

bind dbt_bridge dbt_bridge_sva u_sva
(
	.clk_in(clk_in),
	.rst_b_in(rst_b_in),
	.ce_in(ce_in),
	.req_valid_in(req_valid_in),
	.req_ready_out(req_ready_out),
	.xl_valid_out(xl_valid_out),
	.xl_addr_out(xl_addr_out),
	.xl_id_out(xl_id_out),
	.db_ring_in(db_ring_in),
	.db_ack_in(db_ack_in),
	.db_side_in(db_side_in),
	.db_func_in(db_func_in),
	.db_ring_data_in(db_ring_data_in),
	.db_event_out(db_event_out),
	.rd_en_in(rd_en_in),
	.rd_db_out(rd_db_out)
);

// ===== sim/dbt_bridge_tb_top.sv
// Purpose: Self-checking bench of the bridge
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Clock enable held high
`timescale 1ns/1ps

module dbt_bridge_tb_top
	import dbt_pkg::*;
;
	logic clk_in = 1'h0, rst_b_in = 1'h0, ce_in = 1'h1, cfg_we_in = 1'h0, req_valid_in = 1'h0;
	logic db_ring_in = 1'h0, db_side_in = 1'h0, msg_we_in = 1'h0, msg_side_in = 1'h0;
	logic rd_en_in = 1'h0, rd_side_in = 1'h0, ack_req = 1'h0, db_ack_in;
	logic [2:0] cfg_func_in = 3'h0, req_func_in = 3'h0, db_func_in = 3'h0;
	logic [2:0] msg_func_in = 3'h0, rd_func_in = 3'h0, xl_func_out, xl_win_out;
	dbt_cfg_sel_t cfg_sel_in = DBT_CFG_BASE;
	logic [5:0] cfg_idx_in = 6'h00;
	logic [63:0] cfg_data_in = 64'h0;
	dbt_addr_t req_addr_in = 64'h0, xl_addr_out;
	dbt_id_t req_id_in = 16'h0000, xl_id_out;
	logic [1:0] msg_idx_in = 2'h0, rd_idx_in = 2'h0;
	logic [31:0] db_ring_data_in = 32'h0, msg_data_in = 32'h0, ack_mask = 32'h0;
	logic [31:0] rd_msg_out, rd_db_out, db_ack_data_in;
	logic req_ready_out, xl_valid_out, xl_miss_out;
	logic [15:0] db_event_out, seen;
	int miscompares = 0, checks_done = 0;

	always #12.5 clk_in = ~clk_in;

	dbt_bridge DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .cfg_we_in(cfg_we_in),
		.cfg_func_in(cfg_func_in), .cfg_sel_in(cfg_sel_in), .cfg_idx_in(cfg_idx_in),
		.cfg_data_in(cfg_data_in), .req_valid_in(req_valid_in), .req_func_in(req_func_in),
		.req_addr_in(req_addr_in), .req_id_in(req_id_in), .req_ready_out(req_ready_out),
		.xl_valid_out(xl_valid_out), .xl_miss_out(xl_miss_out), .xl_func_out(xl_func_out),
		.xl_win_out(xl_win_out), .xl_addr_out(xl_addr_out), .xl_id_out(xl_id_out),
		.db_ring_in(db_ring_in), .db_ack_in(db_ack_in), .db_side_in(db_side_in),
		.db_func_in(db_func_in), .db_ring_data_in(db_ring_data_in),
		.db_ack_data_in(db_ack_data_in), .db_event_out(db_event_out), .msg_we_in(msg_we_in),
		.msg_side_in(msg_side_in), .msg_func_in(msg_func_in), .msg_idx_in(msg_idx_in),
		.msg_data_in(msg_data_in), .rd_en_in(rd_en_in), .rd_side_in(rd_side_in),
		.rd_func_in(rd_func_in), .rd_idx_in(rd_idx_in), .rd_msg_out(rd_msg_out),
		.rd_db_out(rd_db_out));

	dbt_host_model host (.clk_in(clk_in), .rst_b_in(rst_b_in), .xl_valid_in(xl_valid_out),
		.db_ack_out(db_ack_in), .db_ack_data_out(db_ack_data_in), .ack_req_in(ack_req),
		.ack_mask_in(ack_mask), .seen_count_out(seen));

	// ==================================================================
	// Shared tasks
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic step;
		@(posedge clk_in);
		#1;
	endtask : step

	task automatic cfg(input logic [2:0] f, input dbt_cfg_sel_t s, input logic [5:0] i,
		input logic [63:0] d);
		cfg_func_in = f;
		cfg_sel_in = s;
		cfg_idx_in = i;
		cfg_data_in = d;
		cfg_we_in = 1'h1;
		step();
		cfg_we_in = 1'h0;
		step();
	endtask : cfg

	task automatic win(input logic [2:0] f, input logic [5:0] w, input dbt_addr_t b, l, x);
		cfg(f, DBT_CFG_BASE, w, b);
		cfg(f, DBT_CFG_LIMIT, w, l);
		cfg(f, DBT_CFG_XLAT, w, x);
	endtask : win

	task automatic req(input logic [2:0] f, input dbt_addr_t a, input dbt_id_t id,
		input logic miss, input logic [2:0] w, input dbt_addr_t xa, input dbt_id_t xid);
		req_func_in = f;
		req_addr_in = a;
		req_id_in = id;
		req_valid_in = 1'h1;
		step();
		req_valid_in = 1'h0;
		chk("xl_valid", 64'h1, xl_valid_out);
		chk("xl_func", f, xl_func_out);
		chk("xl_miss", miss, xl_miss_out);
		if (!miss)
		begin
			chk("xl_win", w, xl_win_out);
			chk("xl_addr", xa, xl_addr_out);
			chk("xl_id", xid, xl_id_out);
		end
		step();
	endtask : req

	task automatic rd(input logic s, input logic [2:0] f, input logic [1:0] i);
		rd_side_in = s;
		rd_func_in = f;
		rd_idx_in = i;
		rd_en_in = 1'h1;
		step();
		rd_en_in = 1'h0;
		step();
	endtask : rd

	task automatic ack(input logic [31:0] m);
		ack_mask = m;
		ack_req = 1'h1;
		step();
		ack_req = 1'h0;
		step();
	endtask : ack

	// ==================================================================
	// Scenarios
	task automatic t_direct;
		win(3'h1, 6'h00, 64'h1000, 64'h1FFF, 64'h8000_0000);
		cfg(3'h1, DBT_CFG_CTL, 6'h00, 64'h1);
		cfg(3'h0, DBT_CFG_MAP, 6'h05, 64'h0000_0003_0200_0100);
		req(3'h1, 64'h1234, 16'h0100, 1'h0, 3'h0, 64'h8000_0234, 16'h0200);
		req(3'h1, 64'h1FFF, 16'h0100, 1'h0, 3'h0, 64'h8000_0FFF, 16'h0200);
		req(3'h1, 64'h2000, 16'h0100, 1'h1, 3'h0, 64'h0, 16'h0);
		req(3'h1, 64'h1_0000_1234, 16'h0100, 1'h1, 3'h0, 64'h0, 16'h0);
		req(3'h0, 64'h1234, 16'h0100, 1'h1, 3'h0, 64'h0, 16'h0);
		req(3'h1, 64'h1234, 16'h0999, 1'h1, 3'h0, 64'h0, 16'h0);
	endtask : t_direct

	task automatic t_wide;
		win(3'h2, 6'h00, 64'h1_0000_0000, 64'h1_FFFF_FFFF, 64'h20_0000_0000);
		cfg(3'h2, DBT_CFG_CTL, 6'h00, 64'h41);
		cfg(3'h0, DBT_CFG_MAP, 6'h03, 64'h0000_0005_0220_0100);
		req(3'h2, 64'h1_0000_0010, 16'h0100, 1'h0, 3'h0, 64'h20_0000_0010, 16'h0220);
	endtask : t_wide

	task automatic t_table;
		win(3'h3, 6'h02, 64'h10_0000, 64'h11_8FFF, 64'h0);
		cfg(3'h3, DBT_CFG_CTL, 6'h00, 64'h000C_0204);
		cfg(3'h3, DBT_CFG_LUT, 6'h15, 64'hABC0_0001);
		cfg(3'h0, DBT_CFG_MAP, 6'h3D, 64'h0000_0007_0400_0300);
		req(3'h3, 64'h11_5012, 16'h0300, 1'h0, 3'h2, 64'hABC0_0012, 16'h0400);
		req(3'h3, 64'h11_8000, 16'h0300, 1'h1, 3'h2, 64'h0, 16'h0);
		req(3'h3, 64'h10_0000, 16'h0300, 1'h1, 3'h2, 64'h0, 16'h0);
	endtask : t_table

	task automatic t_burst;
		logic [15:0] n;
		n = seen;
		for (int i = 0; i < 4; i++)
		begin
			req_func_in = 3'h1;
			req_id_in = 16'h0100;
			req_addr_in = 64'h1000 + 64'(i * 16);
			req_valid_in = 1'h1;
			step();
			chk("burst_valid", 64'h1, xl_valid_out);
			chk("burst_addr", 64'h8000_0000 + 64'(i * 16), xl_addr_out);
		end
		req_valid_in = 1'h0;
		step();
		chk("burst_count", n + 16'h0004, seen);
	endtask : t_burst

	task automatic t_door;
		db_side_in = 1'h0;
		db_func_in = 3'h7;
		db_ring_data_in = 32'h8000_0001;
		db_ring_in = 1'h1;
		step();
		db_ring_in = 1'h0;
		chk("event", 64'h8000, db_event_out);
		rd(1'h1, 3'h7, 2'h0);
		chk("far_db", 64'h8000_0001, rd_db_out);
		rd(1'h0, 3'h7, 2'h0);
		chk("own_db", 64'h0, rd_db_out);
		db_side_in = 1'h1;
		ack(32'h0000_0001);
		rd(1'h1, 3'h7, 2'h0);
		chk("acked_db", 64'h8000_0000, rd_db_out);
		chk("event_kept", 64'h8000, db_event_out);
		ack(32'h8000_0000);
		chk("event_gone", 64'h0, db_event_out);
	endtask : t_door

	task automatic t_msg;
		msg_side_in = 1'h0;
		msg_func_in = 3'h4;
		for (int i = 0; i < 4; i++)
		begin
			msg_idx_in = 2'(i);
			msg_data_in = 32'h1111_1111 * (i + 1);
			msg_we_in = 1'h1;
			step();
		end
		msg_we_in = 1'h0;
		for (int i = 0; i < 4; i++)
		begin
			rd(1'h1, 3'h4, 2'(i));
			chk("msg", 64'(32'h1111_1111 * (i + 1)), rd_msg_out);
		end
		rd(1'h0, 3'h4, 2'h0);
		chk("own_msg", 64'h0, rd_msg_out);
	endtask : t_msg

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// ==================================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (12) @(posedge clk_in);
		#1;
		rst_b_in = 1'h1;
		step();
		chk("ready", 64'h1, req_ready_out);
		chk("event_rst", 64'h0, db_event_out);
		t_direct();
		t_wide();
		t_table();
		t_burst();
		t_door();
		t_msg();
		test_done();
	end

	initial
	begin
		#100000;
		miscompares++;
		test_done();
	end
endmodule : dbt_bridge_tb_top

// ===== sim/dbt_host_model.sv
// Purpose: Far domain host model, sinks translated requests, clears doorbells
// Assumes: Registered outputs on clk_in
// Notes: Idle ack data shows the inverse of its last value
`timescale 1ns/1ps

module dbt_host_model
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Bridge side
	input wire logic xl_valid_in,
	output logic db_ack_out,
	output logic [31:0] db_ack_data_out,
	// Bench control
	input wire logic ack_req_in,
	input wire logic [31:0] ack_mask_in,
	output logic [15:0] seen_count_out
);
	// ==================================================================
	// Request sink, never stalls
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			seen_count_out <= 16'h0000;
		else if (xl_valid_in)
			seen_count_out <= seen_count_out + 16'h0001;
	end

	// ==================================================================
	// Write one to clear
	always_ff @(posedge clk_in)
	begin
		db_ack_out <= rst_b_in && ack_req_in;
		db_ack_data_out <= ack_req_in ? ack_mask_in : ~db_ack_data_out;
	end
endmodule : dbt_host_model
